// [rtl/conv_ctrl.sv]
// conversion control: sync, reset, power-down and filter settings
// assumes pins and serial clock arrive asynchronous to pclk
module conv_ctrl #(
  parameter int base_period = conv_ctrl_pkg::base_period,
  parameter int lat_num     = conv_ctrl_pkg::lat_num
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sync_pin,
  input  wire logic        reset_pin_n,
  input  wire logic        powerdown_n,
  input  wire logic        sclk,
  input  wire logic        din,
  output logic             data_ready_n,
  output logic             dout_hold_low,
  output logic             filter_clear,
  output logic             circuit_enable,
  output logic             fir_phase_select,
  output logic             highpass_enable,
  output logic [15:0]      highpass_coefficient,
  output logic [2:0]       data_rate
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [4:0]  meta_ff;
  logic [4:0]  pins_ff;
  logic        sync_prev_ff;
  logic        sclk_prev_ff;
  // bit order: din, sclk, powerdown, reset, sync; idle levels come out of reset
  wire  [4:0]  pins_raw = {din, sclk, powerdown_n, reset_pin_n, sync_pin};

  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1)
    begin : g_pin
      // two flops per pin; only the second one is read by logic
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          meta_ff[g] <= conv_ctrl_pkg::pins_idle[g];
          pins_ff[g] <= conv_ctrl_pkg::pins_idle[g];
        end
        else
        begin
          meta_ff[g] <= pins_raw[g]; // R21
          pins_ff[g] <= meta_ff[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_prev_ff <= 1'b0;
      sclk_prev_ff <= 1'b0;
    end
    else
    begin
      sync_prev_ff <= pins_ff[0];
      sclk_prev_ff <= pins_ff[3];
    end
  end

  wire sync_rise  = pins_ff[0] & ~sync_prev_ff; // R21
  wire sclk_rise  = pins_ff[3] & ~sclk_prev_ff;
  wire pin_rst    = ~pins_ff[1];
  wire pin_pd     = ~pins_ff[2];
  wire hold_reset = pin_rst | pin_pd; // R14 R18

  // ----------------------------------------
  // serial command shifter
  // ----------------------------------------
  // kept alive in standby so a wake-up can still arrive
  logic [6:0]  shift_ff;
  logic [2:0]  bitcnt_ff;
  wire         cmd_fire    = sclk_rise & (bitcnt_ff == 3'h7) & ~hold_reset;
  wire  [7:0]  opcode      = {shift_ff, pins_ff[4]};
  wire         cmd_sync    = cmd_fire & (opcode == conv_ctrl_pkg::op_sync);
  wire         cmd_reset   = cmd_fire & (opcode == conv_ctrl_pkg::op_reset);
  wire         cmd_standby = cmd_fire & (opcode == conv_ctrl_pkg::op_standby);
  wire         cmd_wakeup  = cmd_fire & (opcode == conv_ctrl_pkg::op_wakeup);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      shift_ff  <= 7'h00;
      bitcnt_ff <= 3'h0;
    end
    else if (hold_reset)
    begin
      shift_ff  <= 7'h00;
      bitcnt_ff <= 3'h0;
    end
    else if (sclk_rise)
    begin
      shift_ff  <= opcode[6:0]; // R19
      bitcnt_ff <= bitcnt_ff + 3'h1;
    end
  end

  // ----------------------------------------
  // configuration registers and apb slave
  // ----------------------------------------
  logic [5:0]  ctrl_ff;
  logic [7:0]  hpf_lo_ff;
  logic [7:0]  hpf_hi_ff;
  logic [31:0] prdata_ff;
  logic        standby_ff;
  logic        resync_req_ff;
  logic        armed_ff;
  logic [7:0]  resync_cnt_ff;

  wire defaults_now = hold_reset | cmd_reset; // R15 R16 R18
  wire sel_ctrl   = paddr == conv_ctrl_pkg::off_ctrl;
  wire sel_hpf_lo = paddr == conv_ctrl_pkg::off_hpf_lo;
  wire sel_hpf_hi = paddr == conv_ctrl_pkg::off_hpf_hi;
  wire sel_status = paddr == conv_ctrl_pkg::off_status;
  wire mapped     = sel_ctrl | sel_hpf_lo | sel_hpf_hi | sel_status;
  wire wr_en      = psel & penable & pwrite & mapped;
  wire setup_ph   = psel & ~penable;
  wire cont_mode  = ctrl_ff[conv_ctrl_pkg::ctrl_cont];
  wire [2:0] dr   = ctrl_ff[conv_ctrl_pkg::ctrl_dr_lsb +: 3];

  logic [31:0] status_word;
  logic [31:0] rd_mux;
  assign status_word = {19'h00000, standby_ff, pin_pd, dout_hold_low, data_ready_n,
                        1'b0, resync_cnt_ff};
  assign rd_mux = sel_ctrl   ? {26'h0000000, ctrl_ff} :
                  sel_hpf_lo ? {24'h000000, hpf_lo_ff} :
                  sel_hpf_hi ? {24'h000000, hpf_hi_ff} :
                  sel_status ? status_word : 32'h00000000;
  assign pready  = penable;
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = prdata_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_ff <= 32'h00000000;
    else if (setup_ph)
      prdata_ff <= rd_mux;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_ff   <= conv_ctrl_pkg::ctrl_reset;
      hpf_lo_ff <= conv_ctrl_pkg::hpf_lo_reset;
      hpf_hi_ff <= conv_ctrl_pkg::hpf_hi_reset;
    end
    else if (defaults_now)
    begin
      ctrl_ff   <= conv_ctrl_pkg::ctrl_reset; // R16 R18
      hpf_lo_ff <= conv_ctrl_pkg::hpf_lo_reset;
      hpf_hi_ff <= conv_ctrl_pkg::hpf_hi_reset;
    end
    else if (wr_en)
    begin
      if (sel_ctrl)
        ctrl_ff <= pwdata[conv_ctrl_pkg::ctrl_width-1:0];
      if (sel_hpf_lo)
        hpf_lo_ff <= pwdata[7:0]; // R3
      if (sel_hpf_hi)
        hpf_hi_ff <= pwdata[7:0]; // R3
    end
  end

  // ----------------------------------------
  // timing derived from the master clock
  // ----------------------------------------
  wire [31:0] period  = 32'(base_period) >> dr; // R4
  wire [31:0] per_lim = period - 32'h1;
  wire [31:0] latency = 32'(lat_num) * (period >> conv_ctrl_pkg::lat_shift)
                        + 32'(conv_ctrl_pkg::lat_clk); // R13
  wire [31:0] wake_lat = latency - 32'(conv_ctrl_pkg::wake_adj); // R20

  // ----------------------------------------
  // sync decision
  // ----------------------------------------
  logic [31:0] cnt_ff;
  logic [31:0] settle_ff;
  logic [5:0]  gap_ff;

  wire run      = ~hold_reset & ~standby_ff; // R17
  // a sync clock whose edges land on a period boundary finds the counter at 0
  wire aligned  = cnt_ff == 32'h0;
  wire pin_sync = sync_rise & (~cont_mode | armed_ff | ~aligned); // R5 R7 R9 R11
  // a wake-up restarts in its own cycle; going through the request flop costs a clock
  wire resync   = ~defaults_now & (pin_sync | cmd_sync | cmd_wakeup | resync_req_ff); // R5 R7 R20
  wire settle_end = ~cont_mode & (settle_ff == 32'h1);
  wire period_end = run & (cnt_ff == per_lim);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      standby_ff    <= 1'b0;
      resync_req_ff <= 1'b1;
      armed_ff      <= 1'b1;
      resync_cnt_ff <= 8'h00;
    end
    else
    begin
      if (defaults_now | cmd_wakeup)
        standby_ff <= 1'b0;
      else if (cmd_standby)
        standby_ff <= 1'b1; // R17 R19
      resync_req_ff <= defaults_now; // R16
      if (~cont_mode)
        armed_ff <= 1'b1;
      else if (sync_rise)
        armed_ff <= 1'b0; // R11
      if (resync)
        resync_cnt_ff <= resync_cnt_ff + 8'h01;
    end
  end

  // ----------------------------------------
  // conversion timing
  // ----------------------------------------
  logic [31:0] nxt_cnt;
  logic [31:0] nxt_settle;
  logic [5:0]  nxt_gap;

  always_comb
  begin
    nxt_cnt = cnt_ff + 32'h1;
    if (~run | resync | period_end | (settle_end & run))
      nxt_cnt = 32'h0; // R6 R10
    nxt_settle = settle_ff;
    if (resync)
      nxt_settle = cmd_wakeup ? wake_lat : latency; // R13 R20
    else if (run & (settle_ff != 32'h0))
      nxt_settle = settle_ff - 32'h1;
    nxt_gap = gap_ff;
    if (resync)
      nxt_gap = 6'(conv_ctrl_pkg::read_gap); // R8 R10
    else if (period_end & (gap_ff != 6'h00))
      nxt_gap = gap_ff - 6'h01;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_ff    <= 32'h0;
      settle_ff <= 32'h0;
      gap_ff    <= 6'h00;
    end
    else
    begin
      cnt_ff    <= nxt_cnt;
      settle_ff <= nxt_settle;
      gap_ff    <= nxt_gap;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // ready pulses high for a few clocks while a new word is loaded
  wire upd_win   = cnt_ff >= (period - 32'(conv_ctrl_pkg::data_ready_n_high));
  wire pulse_hold = ~cont_mode & (settle_ff != 32'h0);
  // continuous mode keeps the ready rhythm; a resync only moves its phase
  wire nxt_data_ready_n_n = ~run | (resync & ~cont_mode) | pulse_hold | upd_win; // R6 R8
  wire nxt_hold   = cont_mode ? (gap_ff != 6'h00) : (settle_ff != 32'h0); // R8

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      data_ready_n   <= 1'b1;
      dout_hold_low  <= 1'b1;
      filter_clear   <= 1'b0;
      circuit_enable <= 1'b0;
    end
    else
    begin
      data_ready_n   <= nxt_data_ready_n_n;
      dout_hold_low  <= nxt_hold | ~run;
      filter_clear   <= resync | defaults_now; // R6 R10
      circuit_enable <= ~pin_pd & ~standby_ff; // R17 R18
    end
  end

  // settings handed to the filter datapath, which lives elsewhere
  assign fir_phase_select     = ctrl_ff[conv_ctrl_pkg::ctrl_phase]; // R1
  assign highpass_enable      = ctrl_ff[conv_ctrl_pkg::ctrl_hpf_en]; // R2
  assign highpass_coefficient = {hpf_hi_ff, hpf_lo_ff}; // R3
  assign data_rate            = dr;
endmodule

// [rtl/conv_ctrl_pkg.sv]
// constants shared by the conversion control block
// assumes a 25 MHz pclk that also serves as the converter master clock
// Contract
// R1: phase bit 0 linear, 1 minimum phase
// R2: last stage first-order recursive high-pass
// R3: corner coefficient held in register pair
// R4: all rates derived from master clock
// R5: sync by pin or command, two modes
// R6: pulse sync restarts, clears, holds ready high
// R7: resync after sync rise or eighth sclk
// R8: continuous: ready toggles, output low 63 periods
// R9: sync clock resyncs only on period mismatch
// R10: every resync restarts filter, 63-reading gap
// R11: first sync edge in continuous mode resyncs
// R12: host holds sync high/low two clocks
// R13: first data after fixed latency formula
// R14: reset pin low holds device in reset
// R15: reset command acts after eighth sclk
// R16: reset loads defaults, resyncs next edge
// R17: powerdown by pin or standby command
// R18: powerdown pin disables and resets registers
// R19: standby keeps serial port and registers
// R20: wake-up latency is data latency minus two
// R21: pins sampled on pclk, sync edges compared
package conv_ctrl_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [11:0] off_ctrl    = 12'h000;
  localparam logic [11:0] off_hpf_lo  = 12'h004;
  localparam logic [11:0] off_hpf_hi  = 12'h008;
  localparam logic [11:0] off_status  = 12'h00c;
  localparam int          ctrl_phase  = 0;
  localparam int          ctrl_cont   = 1;
  localparam int          ctrl_dr_lsb = 2;
  localparam int          ctrl_hpf_en = 5;
  localparam int          ctrl_width  = 6;
  localparam logic [5:0]  ctrl_reset  = 6'h08;
  localparam logic [7:0]  hpf_lo_reset = 8'h32;
  localparam logic [7:0]  hpf_hi_reset = 8'h03;
  localparam logic [4:0]  pins_idle    = 5'h06;
  // ----------------------------------------
  // serial command opcodes (arbitrary values)
  // ----------------------------------------
  localparam logic [7:0]  op_wakeup   = 8'h02;
  localparam logic [7:0]  op_standby  = 8'h04;
  localparam logic [7:0]  op_sync     = 8'h08;
  localparam logic [7:0]  op_reset    = 8'h06;
  // ----------------------------------------
  // timing, in master clock periods; read_gap in output periods
  // ----------------------------------------
  localparam int          base_period = 16384;
  localparam int          lat_num     = 16123;
  localparam int          lat_shift   = 8;
  localparam int          lat_clk     = 468;
  localparam int          wake_adj    = 2;
  localparam int          read_gap    = 63;
  localparam int          data_ready_n_high   = 4;
  localparam int          sync_min_w  = 2;
  localparam int          rst_min_w   = 2;
endpackage

// [testbench/conv_ctrl_properties.sv]
// checker bound onto conv_ctrl
// assumes one pclk domain; pins seen raw
module conv_ctrl_properties (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        sync_pin,
  input wire logic        reset_pin_n,
  input wire logic        powerdown_n,
  input wire logic        data_ready_n,
  input wire logic        dout_hold_low,
  input wire logic        filter_clear,
  input wire logic        circuit_enable,
  input wire logic        fir_phase_select,
  input wire logic [15:0] highpass_coefficient
);
  timeunit 1ns;
  timeprecision 1ns;
  // --------
  // properties
  // --------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic cont_ff;
  logic nxt_cont;
  wire  up = reset_pin_n && powerdown_n;
  wire  wr = psel && penable && pwrite && up;
  // raw pins lead the design by 3 clocks; writes kept clear of that
  assign nxt_cont = !up ? 1'b0 : (wr && paddr == 12'h000) ? pwdata[1] : cont_ff;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      cont_ff <= 1'b0;
    else
      cont_ff <= nxt_cont;
  sequence s_low(sig);
    !sig [*4];
  endsequence
  property p_phase;
    wr && paddr == 12'h000 |=> fir_phase_select == $past(pwdata[0]);
  endproperty
  a_phase: assert property (p_phase) else $error("phase not applied");
  property p_coef;
    wr && paddr == 12'h008 |=> highpass_coefficient[15:8] == $past(pwdata[7:0]);
  endproperty
  a_coef: assert property (p_coef) else $error("coefficient not applied");
  property p_sync;
    $rose(sync_pin) && up && circuit_enable && !cont_ff |-> ##[1:5] filter_clear;
  endproperty
  a_sync: assert property (p_sync) else $error("sync edge ignored");
  property p_pulse_hold;
    filter_clear && !cont_ff && up |=> data_ready_n [*8];
  endproperty
  a_pulse_hold: assert property (p_pulse_hold) else $error("ready not held");
  property p_cont_hold;
    filter_clear && cont_ff && up |=> dout_hold_low;
  endproperty
  a_cont_hold: assert property (p_cont_hold) else $error("output not held");
  property p_pd;
    s_low(powerdown_n) |-> !circuit_enable && highpass_coefficient == 16'h0332;
  endproperty
  a_pd: assert property (p_pd) else $error("powerdown not applied");
  property p_rst;
    s_low(reset_pin_n) |-> data_ready_n && !fir_phase_select;
  endproperty
  a_rst: assert property (p_rst) else $error("reset pin not held");
  property p_data_ready_n;
    $fell(data_ready_n) |-> $past(data_ready_n, 2) && $past(data_ready_n, 4);
  endproperty
  a_data_ready_n: assert property (p_data_ready_n) else $error("ready pulse short");
endmodule
bind conv_ctrl conv_ctrl_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .sync_pin(sync_pin),
  .reset_pin_n(reset_pin_n), .powerdown_n(powerdown_n), .data_ready_n(data_ready_n),
  .dout_hold_low(dout_hold_low), .filter_clear(filter_clear),
  .circuit_enable(circuit_enable), .fir_phase_select(fir_phase_select),
  .highpass_coefficient(highpass_coefficient));

// [testbench/host_model.sv]
// host side: sync, reset, power-down pins and serial commands
// assumes tasks are entered just after a rising pclk edge
module host_model (
  input  wire logic pclk,
  output logic      sync_pin,
  output logic      reset_pin_n,
  output logic      powerdown_n,
  output logic      sclk,
  output logic      din
);
  timeunit 1ns;
  timeprecision 1ns;
  // --------
  // drivers
  // --------
  initial {sync_pin, reset_pin_n, powerdown_n, sclk, din} = 5'h0c;
  // sclk 4 clocks high, 4 low: 320 ns, idle low
  task automatic send_cmd(input logic [7:0] op);
    for (int i = 7; i >= 0; i--)
    begin
      din <= op[i];
      repeat (4) @(posedge pclk);
      sclk <= 1'b1;
      repeat (4) @(posedge pclk);
      sclk <= 1'b0;
    end
    din <= ~op[0];
  endtask
  task automatic pulse_sync();
    sync_pin <= 1'b1;
    repeat (4) @(posedge pclk);
    sync_pin <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask
  // 0 reset pin, 1 power-down; held past the two-flop sampling
  task automatic hold_low(input int pin, input int n);
    if (pin == 0) reset_pin_n <= 1'b0;
    else powerdown_n <= 1'b0;
    repeat (n) @(posedge pclk);
    reset_pin_n <= 1'b1;
    powerdown_n <= 1'b1;
  endtask
endmodule

// [testbench/tb_conv_ctrl.sv]
// self-checking bench for conv_ctrl
// assumes host_model and the bound checker are compiled first
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module tb_conv_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int per = 1024 >> 2;
  localparam int lat = 20 * (per >> 8) + conv_ctrl_pkg::lat_clk;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, err, sync_pin, reset_pin_n;
  logic        powerdown_n, sclk, din, data_ready_n, dout_hold_low, filter_clear;
  logic        circuit_enable, fir_phase_select, highpass_enable;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] highpass_coefficient;
  logic [2:0]  data_rate;
  int          n_fail = 0, samples_checked = 0, cyc = 0, n, ns, c;
  always #20 pclk = ~pclk;
  conv_ctrl #(.base_period(1024), .lat_num(20)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sync_pin(sync_pin),
    .reset_pin_n(reset_pin_n), .powerdown_n(powerdown_n), .sclk(sclk), .din(din),
    .data_ready_n(data_ready_n), .dout_hold_low(dout_hold_low), .filter_clear(filter_clear),
    .circuit_enable(circuit_enable), .fir_phase_select(fir_phase_select),
    .highpass_enable(highpass_enable), .highpass_coefficient(highpass_coefficient),
    .data_rate(data_rate));
  host_model host (.pclk(pclk), .sync_pin(sync_pin), .reset_pin_n(reset_pin_n),
    .powerdown_n(powerdown_n), .sclk(sclk), .din(din));
  // --------
  // tasks
  // --------
  task automatic print_verdict();
    if (n_fail == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000) begin n_fail++; print_verdict(); end
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK("prdata", e, rd)
  endtask
  // counts negedges until ready falls after being seen high
  task automatic time_fall(output int cnt);
    logic seen;
    seen = 1'b0;
    cnt = 0;
    while (!(seen && data_ready_n === 1'b0) && cnt < 3000)
    begin
      @(negedge pclk);
      cnt++;
      if (data_ready_n === 1'b1) seen = 1'b1;
    end
  endtask
  task automatic cmd_clr(input logic [7:0] op, output int cnt);
    cnt = 0;
    fork
      host.send_cmd(op);
      repeat (72) @(negedge pclk) cnt += (filter_clear === 1'b1);
    join
    @(posedge pclk);
  endtask
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rchk(12'h000, 32'h08);
    rchk(12'h004, 32'h32);
    rchk(12'h008, 32'h03);
    apb(1'b0, 12'h010, 32'h0);
    `CHK("pslverr", 1'b1, err)
    apb(1'b1, 12'h000, 32'h29);
    apb(1'b1, 12'h008, 32'h01);
    apb(1'b1, 12'h004, 32'h9a);
    `CHK("phase", 1'b1, fir_phase_select)
    `CHK("hpf_en", 1'b1, highpass_enable)
    `CHK("coef", 16'h019a, highpass_coefficient)
    `CHK("rate", 3'h2, data_rate)
    fork host.pulse_sync(); time_fall(ns); join
    `CHK("settle", 1'b1, ns >= lat + 2 && ns <= lat + 5)
    time_fall(n);
    `CHK("period", per, n)
    @(posedge pclk);
    cmd_clr(conv_ctrl_pkg::op_sync, c);
    `CHK("sync_clr", 1, c)
    cmd_clr(conv_ctrl_pkg::op_reset, c);
    `CHK("reset_clr", 2, c)
    `CHK("phase_dflt", 1'b0, fir_phase_select)
    apb(1'b1, 12'h004, 32'h55);
    cmd_clr(conv_ctrl_pkg::op_standby, c);
    `CHK("standby_clr", 0, c)
    `CHK("standby", 1'b0, circuit_enable)
    rchk(12'h004, 32'h55);
    fork cmd_clr(conv_ctrl_pkg::op_wakeup, c); time_fall(n); join
    `CHK("wake", ns - 2, n - 60)
    `CHK("wake_clr", 1, c)
    `CHK("awake", 1'b1, circuit_enable)
    @(posedge pclk);
    apb(1'b1, 12'h000, 32'h0a);
    fork
      host.pulse_sync();
      begin
        c = 0;
        repeat (8) @(negedge pclk) c += (filter_clear === 1'b1);
      end
    join
    `CHK("cont_clr", 1, c)
    `CHK("hold_low", 1'b1, dout_hold_low)
    time_fall(n);
    // next fall one period after the resync, counted from the end of the pulse
    `CHK("toggle", per - 3, n)
    @(posedge pclk);
    apb(1'b1, 12'h000, 32'h08);
    host.hold_low(1, 8);
    repeat (4) @(posedge pclk);
    `CHK("pd_coef", 16'h0332, highpass_coefficient)
    fork host.hold_low(0, 12); begin repeat (5) @(posedge pclk); apb(1'b1, 12'h000, 32'h09); end join
    repeat (4) @(posedge pclk);
    `CHK("rst_hold", 1'b0, fir_phase_select)
    print_verdict();
  end
endmodule
